//--- shared/pulse_mod_pkg.sv
// Package: constants for the pulse modulation driver and timing generator.
// Assumes a single 25 MHz system clock; all windows are counted in cycles.
package pulse_mod_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 25000000;
  localparam int ADC_HOLD_US     = 1000;   // 1 msec converter tail
  localparam int INTEG_MIN_US    = 10;     // Normal minimum gate time
  localparam int INTEG_FAST_US   = 1;      // Fast minimum gate time
  localparam int SETTLE_CYC      = 4;      // RF stable delay before gate
  // Least times truncate: the clock is taken in whole MHz
  localparam int ADC_HOLD_CYC  = (ADC_HOLD_US * (CLK_HZ / 1000000));
  localparam int INTEG_MIN_CYC = (INTEG_MIN_US * (CLK_HZ / 1000000));
  localparam int INTEG_FAST_CYC = (INTEG_FAST_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_RF_ON = 1'b0;
  localparam logic RST_GATE  = 1'b0;

endpackage

//--- verilog/window_timer.sv
// Window timer: loads a count and reports busy until it runs out.
// Assumes the caller holds the clock enable and a synchronous reset.
`timescale 1ns/1ps
module window_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output      logic         busy_out
);
  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // A zero-width counter could never hold a window
  if (W < 1) begin : g_bad_width
    $error("window_timer: counter width must be at least one bit");
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [W-1:0] cnt_r;

  // Load wins over the decrement so a fresh event restarts the window
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
    end else if (ce_in) begin
      if (load_in) begin
        cnt_r <= count_in;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

  assign busy_out = (cnt_r != '0);
endmodule

//--- verilog/pulse_mod_timing_driver.sv
// Pulse modulation driver and leveling loop timing generator.
// Assumes the pulse input is synchronous or comes via the two-stage
// synchroniser here; the pull-up is modelled by a drive-present input.
`timescale 1ns/1ps

// Operation
// - Pulse low turns RF off, high on
// - Undriven pulse input reads as high
// - Route drive to band0 or band1-4 modulator
// - Three timing outputs per pulse
// - Sample while RF on, hold when off
// - Converter enabled on, plus 1 msec after
// - Integrator gate closes only once RF stable
// - Normal mode gate closed at least 10 usec
// - Fast mode minimum closed time 1 usec
module pulse_mod_timing_driver #(
  parameter int ADC_CYC   = pulse_mod_pkg::ADC_HOLD_CYC,
  parameter int NORM_CYC  = pulse_mod_pkg::INTEG_MIN_CYC,
  parameter int FAST_CYC  = pulse_mod_pkg::INTEG_FAST_CYC,
  parameter int STAB_CYC  = pulse_mod_pkg::SETTLE_CYC
) (
  input  wire logic CLOCK_IN,
  input  wire logic RSTN_IN,
  input  wire logic CE_IN,
  input  wire logic PULSE_IN,
  input  wire logic PULSE_DRIVEN_IN,
  input  wire logic BAND_ZERO_IN,
  input  wire logic FAST_RESPONSE_IN,
  output      logic RF_ON_OUT,
  output      logic MOD0_DRIVE_OUT,
  output      logic MOD14_DRIVE_OUT,
  output      logic SAMPLE_OUT,
  output      logic ADC_EN_OUT,
  output      logic INTEG_CLOSE_OUT
);
  localparam int W = pulse_mod_pkg::CNT_W;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (ADC_CYC < 1 || ADC_CYC >= (1 << W) || NORM_CYC < 1 ||
      NORM_CYC >= (1 << W) || FAST_CYC < 1 || FAST_CYC > NORM_CYC ||
      STAB_CYC < 1 || STAB_CYC >= (1 << W)) begin : g_bad
    $error("pulse_mod_timing_driver: timing parameter out of range");
  end

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  logic pulse_raw;
  logic sync1_r;
  logic sync2_r;
  logic rf_r;
  logic rf_prev_r;
  logic fast_r;
  logic band0_r;

  // An open input floats high through the pull-up
  assign pulse_raw = PULSE_IN | ~PULSE_DRIVEN_IN;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (CE_IN) begin
      sync1_r <= pulse_raw;
      sync2_r <= sync1_r;
    end
  end

  // RF state register, mode and band latched with it
  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      rf_r      <= pulse_mod_pkg::RST_RF_ON;
      rf_prev_r <= pulse_mod_pkg::RST_RF_ON;
      fast_r    <= 1'b0;
      band0_r   <= 1'b0;
    end else if (CE_IN) begin
      rf_r      <= sync2_r;
      rf_prev_r <= rf_r;
      fast_r    <= FAST_RESPONSE_IN;
      band0_r   <= BAND_ZERO_IN;
    end
  end

  // ----------------------------------------------------------------------
  // Modulator drive routing
  // ----------------------------------------------------------------------
  // Drive is current into the modulator while RF is to be off
  logic drive_on;
  assign drive_on        = ~rf_r & RSTN_IN;
  assign MOD0_DRIVE_OUT  = drive_on & band0_r;
  assign MOD14_DRIVE_OUT = drive_on & ~band0_r;
  assign RF_ON_OUT       = rf_r;

  // ----------------------------------------------------------------------
  // Timing windows
  // ----------------------------------------------------------------------
  logic rf_fall;
  logic rf_rise;
  logic adc_busy;
  logic stab_busy;
  logic min_busy;
  logic stable;
  logic min_load;
  logic [W-1:0] min_count;
  logic stable_prev_r;

  assign rf_fall = rf_prev_r & ~rf_r;
  assign rf_rise = ~rf_prev_r & rf_r;

  // Converter tail after RF drops; droop spoils the held value later
  window_timer #(.W(W)) u_adc (
    .clk_in   (CLOCK_IN),
    .rstn_in  (RSTN_IN),
    .ce_in    (CE_IN),
    .load_in  (rf_fall),
    .count_in (W'(ADC_CYC)),
    .busy_out (adc_busy)
  );

  // Settling delay after RF rises before the integrator trusts it
  window_timer #(.W(W)) u_stab (
    .clk_in   (CLOCK_IN),
    .rstn_in  (RSTN_IN),
    .ce_in    (CE_IN),
    .load_in  (rf_rise),
    .count_in (W'(STAB_CYC)),
    .busy_out (stab_busy)
  );

  assign stable = rf_r & ~rf_rise & ~stab_busy;

  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      stable_prev_r <= 1'b0;
    end else if (CE_IN) begin
      stable_prev_r <= stable;
    end
  end

  // Minimum closed time starts when the gate first closes
  assign min_load  = stable & ~stable_prev_r & ~min_busy;
  assign min_count = fast_r ? W'(FAST_CYC) : W'(NORM_CYC);

  window_timer #(.W(W)) u_min (
    .clk_in   (CLOCK_IN),
    .rstn_in  (RSTN_IN),
    .ce_in    (CE_IN),
    .load_in  (min_load),
    .count_in (min_count),
    .busy_out (min_busy)
  );

  // ----------------------------------------------------------------------
  // Timing outputs, registered
  // ----------------------------------------------------------------------
  logic sample_nxt;
  logic adc_nxt;
  logic integ_nxt;
  assign sample_nxt = rf_r;
  assign adc_nxt    = rf_r | rf_fall | adc_busy;
  assign integ_nxt  = stable | min_load | min_busy;

  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      SAMPLE_OUT      <= pulse_mod_pkg::RST_GATE;
      ADC_EN_OUT      <= pulse_mod_pkg::RST_GATE;
      INTEG_CLOSE_OUT <= pulse_mod_pkg::RST_GATE;
    end else if (CE_IN) begin
      SAMPLE_OUT      <= sample_nxt;
      ADC_EN_OUT      <= adc_nxt;
      INTEG_CLOSE_OUT <= integ_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_rf_drop;
    CE_IN && rf_fall;
  endsequence

  property p_rf_follow;
    CE_IN |=> (rf_r == $past(sync2_r));
  endproperty
  a_rf_follow: assert property (p_rf_follow)
    else $error("RF state does not follow input");

  property p_open_high;
    (CE_IN && !PULSE_DRIVEN_IN) ##1 CE_IN ##1 CE_IN |=> rf_r;
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("Open input did not turn RF on");

  property p_route;
    !rf_r |-> (MOD0_DRIVE_OUT == band0_r) && (MOD14_DRIVE_OUT == !band0_r);
  endproperty
  a_route: assert property (p_route)
    else $error("Modulator drive misrouted");

  property p_sample;
    CE_IN |=> SAMPLE_OUT == $past(rf_r);
  endproperty
  a_sample: assert property (p_sample)
    else $error("Sample gate wrong");

  property p_adc_tail;
    s_rf_drop ##1 (CE_IN && !rf_r) [*8] |=> ADC_EN_OUT;
  endproperty
  a_adc_tail: assert property (p_adc_tail)
    else $error("Converter enable dropped early");

  property p_adc_on;
    (CE_IN && rf_r) |=> ADC_EN_OUT;
  endproperty
  a_adc_on: assert property (p_adc_on)
    else $error("Converter not enabled with RF on");

  property p_integ_hold;
    (CE_IN && !rf_r && !min_busy && !min_load) |=> !INTEG_CLOSE_OUT;
  endproperty
  a_integ_hold: assert property (p_integ_hold)
    else $error("Integrator gate closed without stable RF");

  property p_min_time;
    (CE_IN && min_load) |=> min_busy;
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("Minimum gate window not started");
endmodule

//--- tb/pulse_src_model.sv
// Partner model: external pulse source plugged into the pulse jack.
// Assumes the bench sets plug state and level just after a clock edge.
`timescale 1ns/1ps
module pulse_src_model (
  input  wire logic plug_in,
  input  wire logic level_in,
  output      logic pulse_out,
  output      logic driven_out
);
  // Open jack: the pull-up sits inside the device, so the bare line shows
  // the opposite level; only the device's own pull-up makes it read high
  assign pulse_out  = plug_in ? level_in : 1'b0;
  assign driven_out = plug_in;
endmodule

//--- tb/test_pulse_mod_timing_driver.sv
// Testbench: pulse driver with shortened timing windows.
// Assumes a 25 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
module test_pulse_mod_timing_driver;
  localparam int ADC_C  = 20;
  localparam int NORM_C = 10;
  localparam int FAST_C = 2;
  logic        clock_in = 1'b0;
  logic        rstn_in  = 1'b0;
  logic        ce_in    = 1'b1;
  logic        plug     = 1'b1;
  logic        level    = 1'b1;
  logic        band0    = 1'b0;
  logic        fast     = 1'b0;
  logic        pulse_w, driven_w, rf, m0, m14, smp, adc, integ;
  logic [31:0] seed     = 32'h0001222B;
  int          miscompares = 0;
  int          checked     = 0;
  int          n, w;
  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  initial begin
    forever #20 clock_in = ~clock_in;
  end
  pulse_src_model src (.plug_in(plug), .level_in(level),
    .pulse_out(pulse_w), .driven_out(driven_w));
  pulse_mod_timing_driver #(.ADC_CYC(ADC_C), .NORM_CYC(NORM_C),
    .FAST_CYC(FAST_C), .STAB_CYC(4)) uut (.CLOCK_IN(clock_in),
    .RSTN_IN(rstn_in), .CE_IN(ce_in), .PULSE_IN(pulse_w),
    .PULSE_DRIVEN_IN(driven_w), .BAND_ZERO_IN(band0),
    .FAST_RESPONSE_IN(fast), .RF_ON_OUT(rf), .MOD0_DRIVE_OUT(m0),
    .MOD14_DRIVE_OUT(m14), .SAMPLE_OUT(smp), .ADC_EN_OUT(adc),
    .INTEG_CLOSE_OUT(integ));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Level the jack presents, pull-up included
  function automatic logic eff();
    return plug ? level : 1'b1;
  endfunction
  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %b, wanted %b", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  // Steady-state view once inputs have been held long enough
  task automatic steady();
    check(rf, eff());
    check(m0, !eff() && band0);
    check(m14, !eff() && !band0);
    check(smp, eff());
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard: whole run needs far fewer cycles than this
  initial begin
    #(40 * 20000);
    miscompares++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    check(rf | smp | adc | integ | m0 | m14, 1'b0);
    rstn_in = 1'b1;
    tick(6);
    check(adc, 1'b1);
    plug = 1'b0;
    level = 1'b0;
    tick(6);
    steady();
    for (int b = 0; b < 2; b++) begin
      plug = 1'b1;
      band0 = b[0];
      tick(6);
      steady();
    end
    // Converter tail after RF drops, counted from the drop
    level = 1'b1;
    tick(30);
    level = 1'b0;
    tick(3);
    n = 0;
    while (adc === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check(n >= ADC_C && n <= ADC_C + 3, 1'b1);
    // Narrow pulses: gate must wait for stable RF, then hold its minimum
    for (int k = 0; k < 6; k++) begin
      fast = k[0];
      tick(30);
      w = 7 + int'(rnd() % 2);
      level = 1'b1;
      tick(4);
      check(integ, 1'b0);
      n = 0;
      for (int c = 4; c < 40; c++) begin
        if (c == w) level = 1'b0;
        if (integ === 1'b1) n++;
        tick(1);
      end
      check(n >= (fast ? FAST_C : NORM_C), 1'b1);
      check(n <= (fast ? FAST_C : NORM_C) + 2, 1'b1);
    end
    // Clock enable low must freeze the pipeline
    level = 1'b1;
    tick(10);
    ce_in = 1'b0;
    level = 1'b0;
    tick(8);
    check(rf, 1'b1);
    ce_in = 1'b1;
    tick(6);
    check(rf, 1'b0);
    // Random levels, bands and modes held long enough to settle
    repeat (60) begin
      plug = (rnd() % 4) != 0;
      level = 1'(rnd() % 2);
      band0 = 1'(rnd() % 2);
      fast = 1'(rnd() % 2);
      tick(5 + int'(rnd() % 10));
      steady();
    end
    // Second reset mid-run
    rstn_in = 1'b0;
    tick(2);
    check(rf | smp | adc | integ | m0 | m14, 1'b0);
    // Release again: the pipeline must refill and follow the jack
    rstn_in = 1'b1;
    tick(6);
    steady();
    end_of_test();
  end
endmodule
